// file: src/tw_pkg.sv
// Constants, register indices, field layout and state encodings of the two-wire block
package tw_pkg;

  // ----------------------------------------------------------------
  // Bus geometry and register indices (byte address is index * 4)
  // ----------------------------------------------------------------
  localparam int          ADR_W     = 10;
  localparam logic [7:0]  IDX_CTRL  = 8'hC0;
  localparam logic [7:0]  IDX_CODE  = 8'hC1;
  localparam logic [7:0]  IDX_DATA  = 8'hC2;
  localparam logic [7:0]  IDX_ADDR  = 8'hC3;
  localparam logic [7:0]  IDX_RATE  = 8'hCF;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  RST_CTRL  = 8'h00;
  localparam logic [7:0]  RST_ADDR  = 8'h00;
  localparam logic [7:0]  RST_RATE  = 8'h00;
  localparam logic [7:0]  RST_DATA  = 8'h00;

  // ----------------------------------------------------------------
  // State codes, all multiples of eight
  // ----------------------------------------------------------------
  localparam logic [7:0]  CODE_START   = 8'h08;
  localparam logic [7:0]  CODE_RSTART  = 8'h10;
  localparam logic [7:0]  CODE_AW_ACK  = 8'h18;
  localparam logic [7:0]  CODE_AW_NACK = 8'h20;
  localparam logic [7:0]  CODE_DT_ACK  = 8'h28;
  localparam logic [7:0]  CODE_DT_NACK = 8'h30;
  localparam logic [7:0]  CODE_ARB     = 8'h38;
  localparam logic [7:0]  CODE_AR_ACK  = 8'h40;
  localparam logic [7:0]  CODE_AR_NACK = 8'h48;
  localparam logic [7:0]  CODE_DR_ACK  = 8'h50;
  localparam logic [7:0]  CODE_DR_NACK = 8'h58;
  localparam logic [7:0]  CODE_IDLE    = 8'hF8;

  // ----------------------------------------------------------------
  // Timing and counting
  // ----------------------------------------------------------------
  localparam logic [3:0]  ACK_BIT     = 4'h8;
  localparam logic [3:0]  LAST_BIT    = 4'h7;
  localparam logic [3:0]  FREE_LAST   = 4'h9;
  localparam logic [6:0]  GEN_CALL    = 7'h00;
  localparam logic [7:0]  TIMER_LAST  = 8'hFF;

  // ----------------------------------------------------------------
  // Control register layout, bit 7 down to bit 0
  // ----------------------------------------------------------------
  typedef struct packed {
    logic busy;
    logic enable;
    logic start_request;
    logic stop_request;
    logic event_flag;
    logic ack_assert;
    logic free_enable;
    logic addr_match;
  } tw_ctl_t;

  typedef enum logic [7:0] {
    S_IDLE   = 8'h01,
    S_START  = 8'h02,
    S_LOW    = 8'h04,
    S_HIGH   = 8'h08,
    S_HOLD   = 8'h10,
    S_STOP   = 8'h20,
    S_STOPHI = 8'h40,
    S_RSLOW  = 8'h80
  } tw_state_t;

endpackage

// file: src/tw_rate_timer.sv
// Preset-loaded up-counter that pulses on each rollover
`timescale 1ns/1ns
module tw_rate_timer
  import tw_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input  wire logic             clk_sys_in,
  input  wire logic             reset_in,
  input  wire logic             ce_in,
  input  wire logic             run_in,
  input  wire logic [WIDTH-1:0] preset_in,
  output      logic             tick_out
);

  logic [WIDTH-1:0] count;

  assign tick_out = run_in && (count == {WIDTH{1'b1}});

  // Held at preset while idle, reloaded at every rollover
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      count <= '0;
    end else if (ce_in) begin
      if (!run_in || tick_out) begin
        count <= preset_in;
      end else begin
        count <= count + 1'b1;
      end
    end
  end

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);

  reload_a: assert property (ce_in && tick_out |=> count == $past(preset_in))
    else $error("rate timer not reloaded after rollover");
  count_up_a: assert property (ce_in && run_in && !tick_out |=> count == $past(count) + 1'b1)
    else $error("rate timer did not count up");

endmodule

// file: src/tw_twowire.sv
// Two-wire bus master engine with rate timer, shift data, address and state code registers
`timescale 1ns/1ns
// Behaviour
// - Master clock timer loads preset, counts up, toggles SCL at all ones and reloads the preset.
// - SCL low lasts 256 minus preset cycles; high adds line settling.
// - Bus free timeout is about ten timer periods of idle high lines.
// - Bytes leave most significant bit first; first received bit lands in MSB.
// - While sending, bus data shifts in, so arbitration loss keeps correct data.
// - Slave address compares against own address bits 7..1; unused in master mode.
// - Own address bit 0 enables recognising the general call address zero.
// - Each state has a unique code with low three bits zero.
// - Code 0x08 after START, 0x10 after repeated START; software loads address.
// - Address plus write: 0x18 when acknowledged, 0x20 when not.
// - Data byte sent: 0x28 when acknowledged, 0x30 when not.
// - Address plus read acknowledged gives 0x40; software may clear ack assert.
// - Unacknowledged address gives 0x20 or 0x48; stop plus start retries.
// - Received byte gives 0x50 when acknowledged, 0x58 when not.
// - Event flag sets on every non-idle state entry; only software clears it.
// - While event flag set and SCL low, SCL stays held low until software clears the event flag or enable.
// - Stop request clears itself when a STOP is seen on the bus.
module tw_twowire
  import tw_pkg::*;
(
  input  wire logic             clk_sys_in,
  input  wire logic             reset_in,
  input  wire logic             ce_in,
  input  wire logic             wb_cyc_in,
  input  wire logic             wb_stb_in,
  input  wire logic             wb_we_in,
  input  wire logic [ADR_W-1:0] wb_adr_in,
  input  wire logic [3:0]       wb_sel_in,
  input  wire logic [31:0]      wb_dat_in,
  output      logic [31:0]      wb_dat_out,
  output      logic             wb_ack_out,
  input  wire logic             scl_in,
  output      logic             scl_out,
  output      logic             scl_oe_out,
  input  wire logic             sda_in,
  output      logic             sda_out,
  output      logic             sda_oe_out
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  tw_state_t  state, next_state;
  logic       scl_low, next_scl_low, sda_low, next_sda_low;
  logic [3:0] bit_cnt, next_bit;
  logic [7:0] shift, next_shift, state_code, next_code;
  logic       rx_mode, next_rx, addr_ph, next_addr_ph, master, next_master;
  logic       set_evt;
  logic       enable, start_req, stop_req, event_flag, ack_assert, free_en;
  logic       busy, addr_match;
  logic [7:0] own, rate;
  logic       wb_ack;
  logic [31:0] wb_dat;
  logic       scl_m, scl_s, scl_p, sda_m, sda_s, sda_p;
  logic [3:0] free_cnt, sl_cnt;
  logic [7:0] sl_shift;
  logic       sl_active;
  logic [8:0] lo_cnt;

  // ----------------------------------------------------------------
  // Register bus decode
  // ----------------------------------------------------------------
  wire        req      = wb_cyc_in && wb_stb_in;
  wire [7:0]  idx      = wb_adr_in[ADR_W-1:2];
  wire        wr       = req && wb_we_in && wb_ack && wb_sel_in[0];
  wire [7:0]  wdat     = wb_dat_in[7:0];
  wire        hit_ctrl = idx == IDX_CTRL;
  wire        hit_code = idx == IDX_CODE;
  wire        hit_data = idx == IDX_DATA;
  wire        hit_addr = idx == IDX_ADDR;
  wire        hit_rate = idx == IDX_RATE;
  wire        wr_ctrl  = wr && hit_ctrl;
  wire        wr_data  = wr && hit_data;
  tw_ctl_t    wctl;
  tw_ctl_t    ctl_view;
  assign wctl     = tw_ctl_t'(wdat);
  assign ctl_view = '{busy, enable, start_req, stop_req, event_flag,
                      ack_assert, free_en, addr_match};
  wire        clr_evt  = wr_ctrl && !wctl.event_flag;
  wire [7:0]  rd_byte  = hit_ctrl ? ctl_view :
                         hit_code ? state_code :
                         hit_data ? shift :
                         hit_addr ? own :
                         hit_rate ? rate : 8'h00;

  assign wb_ack_out = wb_ack;
  assign wb_dat_out = wb_dat;

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      wb_ack <= 1'b0;
      wb_dat <= 32'h0000_0000;
    end else if (ce_in) begin
      wb_ack <= req && !wb_ack;
      wb_dat <= {24'h00_0000, rd_byte};
    end
  end

  // ----------------------------------------------------------------
  // Pin synchronisers and bus condition detection
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      {scl_m, scl_s, scl_p} <= 3'h7;
      {sda_m, sda_s, sda_p} <= 3'h7;
    end else if (ce_in) begin
      {scl_m, scl_s, scl_p} <= {scl_in, scl_m, scl_s};
      {sda_m, sda_s, sda_p} <= {sda_in, sda_m, sda_s};
    end
  end

  wire start_seen = scl_s && scl_p && sda_p && !sda_s;
  wire stop_seen  = scl_s && scl_p && !sda_p && sda_s;
  wire scl_rise   = scl_s && !scl_p;

  // ----------------------------------------------------------------
  // Rate timers: one paces SCL, one measures bus-free time
  // ----------------------------------------------------------------
  wire moving   = !(state inside {S_IDLE, S_HOLD});
  wire stretch  = !scl_low && !scl_s;
  wire run      = enable && moving && !stretch;
  wire free_run = enable && free_en && busy && scl_s && sda_s;
  wire tick, ftick;
  wire free_to  = free_run && ftick && (free_cnt == FREE_LAST);

  tw_rate_timer #(.WIDTH(8)) u_scl_timer (
    .clk_sys_in (clk_sys_in),
    .reset_in   (reset_in),
    .ce_in      (ce_in),
    .run_in     (run),
    .preset_in  (rate),
    .tick_out   (tick)
  );

  tw_rate_timer #(.WIDTH(8)) u_free_timer (
    .clk_sys_in (clk_sys_in),
    .reset_in   (reset_in),
    .ce_in      (ce_in),
    .run_in     (free_run),
    .preset_in  (rate),
    .tick_out   (ftick)
  );

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      free_cnt <= 4'h0;
      busy     <= 1'b0;
    end else if (ce_in) begin
      free_cnt <= (!free_run || free_to) ? 4'h0 : free_cnt + {3'h0, ftick};
      busy     <= start_seen || (busy && !stop_seen && !free_to && enable);
    end
  end

  // ----------------------------------------------------------------
  // Master engine next state
  // ----------------------------------------------------------------
  wire [7:0] shift_nx = {shift[6:0], sda_s};
  wire       acked    = !sda_s;
  wire       arb      = !rx_mode && (bit_cnt != ACK_BIT) && !sda_low && !sda_s;
  wire [7:0] addr_code = shift[0] ? (acked ? CODE_AR_ACK : CODE_AR_NACK)
                                  : (acked ? CODE_AW_ACK : CODE_AW_NACK);
  wire [7:0] data_code = rx_mode ? (sda_low ? CODE_DR_ACK : CODE_DR_NACK)
                                 : (acked ? CODE_DT_ACK : CODE_DT_NACK);
  wire [7:0] ack_code  = addr_ph ? addr_code : data_code;

  always_comb begin
    next_state   = state;
    next_scl_low = scl_low;
    next_sda_low = sda_low;
    next_bit     = bit_cnt;
    next_shift   = wr_data ? wdat : shift;
    next_code    = state_code;
    next_rx      = rx_mode;
    next_addr_ph = addr_ph;
    next_master  = master;
    set_evt      = 1'b0;
    if (!enable) begin
      next_state   = S_IDLE;
      next_scl_low = 1'b0;
      next_sda_low = 1'b0;
      next_master  = 1'b0;
      next_code    = CODE_IDLE;
    end else begin
      unique case (state)
        S_IDLE: begin
          if (start_req && !busy && !event_flag) begin
            next_state   = S_START;
            next_sda_low = 1'b1;
          end
        end
        S_START: begin
          if (tick && !sda_low) begin
            next_sda_low = 1'b1;
          end else if (tick) begin
            next_scl_low = 1'b1;
            next_code    = master ? CODE_RSTART : CODE_START;
            next_master  = 1'b1;
            next_addr_ph = 1'b1;
            next_rx      = 1'b0;
            set_evt      = 1'b1;
            next_state   = S_HOLD;
          end
        end
        S_HOLD: begin
          if (!event_flag && stop_req) begin
            next_sda_low = 1'b1;
            next_state   = S_STOP;
          end else if (!event_flag && start_req) begin
            next_sda_low = 1'b0;
            next_state   = S_RSLOW;
          end else if (!event_flag) begin
            next_bit     = 4'h0;
            next_sda_low = !rx_mode && !shift[7];
            next_state   = S_LOW;
          end
        end
        S_LOW: begin
          if (tick) begin
            next_scl_low = 1'b0;
            next_state   = S_HIGH;
          end
        end
        S_HIGH: begin
          if (tick && arb) begin
            next_shift   = shift_nx;
            next_sda_low = 1'b0;
            next_code    = CODE_ARB;
            next_master  = 1'b0;
            set_evt      = 1'b1;
            next_state   = S_IDLE;
          end else if (tick && bit_cnt == ACK_BIT) begin
            next_scl_low = 1'b1;
            next_sda_low = 1'b0;
            next_code    = ack_code;
            next_addr_ph = 1'b0;
            next_rx      = rx_mode || (addr_ph && shift[0] && acked);
            set_evt      = 1'b1;
            next_state   = S_HOLD;
          end else if (tick) begin
            next_shift   = shift_nx;
            next_scl_low = 1'b1;
            next_bit     = bit_cnt + 4'h1;
            next_sda_low = (bit_cnt == LAST_BIT) ? (rx_mode && ack_assert)
                                                 : (!rx_mode && !shift_nx[7]);
            next_state   = S_LOW;
          end
        end
        S_STOP: begin
          if (tick) begin
            next_scl_low = 1'b0;
            next_state   = S_STOPHI;
          end
        end
        S_STOPHI: begin
          if (tick) begin
            next_sda_low = 1'b0;
            next_master  = 1'b0;
            next_code    = CODE_IDLE;
            next_state   = S_IDLE;
          end
        end
        S_RSLOW: begin
          if (tick) begin
            next_scl_low = 1'b0;
            next_state   = S_START;
          end
        end
        default: begin
          next_state   = S_IDLE;
          next_scl_low = 1'b0;
          next_sda_low = 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Master engine registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      state      <= S_IDLE;
      scl_low    <= 1'b0;
      sda_low    <= 1'b0;
      bit_cnt    <= 4'h0;
      shift      <= RST_DATA;
      state_code <= CODE_IDLE;
      {rx_mode, addr_ph, master} <= 3'h0;
    end else if (ce_in) begin
      state      <= next_state;
      scl_low    <= next_scl_low;
      sda_low    <= next_sda_low;
      bit_cnt    <= next_bit;
      shift      <= next_shift;
      state_code <= next_code;
      {rx_mode, addr_ph, master} <= {next_rx, next_addr_ph, next_master};
    end
  end

  assign scl_out    = 1'b0;
  assign sda_out    = 1'b0;
  assign scl_oe_out = scl_low;
  assign sda_oe_out = sda_low;

  // ----------------------------------------------------------------
  // Software registers; hardware set and clear win over writes
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      {enable, start_req, ack_assert, free_en} <= 4'h0;
      stop_req   <= 1'b0;
      event_flag <= 1'b0;
      own        <= RST_ADDR;
      rate       <= RST_RATE;
    end else if (ce_in) begin
      if (wr_ctrl) begin
        {enable, start_req} <= {wctl.enable, wctl.start_request};
        {ack_assert, free_en} <= {wctl.ack_assert, wctl.free_enable};
      end
      stop_req   <= !stop_seen && (wr_ctrl ? wctl.stop_request : stop_req);
      event_flag <= set_evt || (event_flag && !clr_evt);
      if (wr && hit_addr) begin
        own <= wdat;
      end
      if (wr && hit_rate) begin
        rate <= wdat;
      end
    end
  end

  // ----------------------------------------------------------------
  // Own address and general call recognition while not master
  // ----------------------------------------------------------------
  wire [7:0] sl_nx   = {sl_shift[6:0], sda_s};
  wire       sl_done = sl_active && scl_rise && (sl_cnt == LAST_BIT);
  wire       own_hit = sl_nx[7:1] == own[7:1];
  wire       gc_hit  = own[0] && (sl_nx[7:1] == GEN_CALL);

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      sl_active  <= 1'b0;
      sl_cnt     <= 4'h0;
      sl_shift   <= 8'h00;
      addr_match <= 1'b0;
    end else if (ce_in) begin
      if (start_seen) begin
        sl_active  <= enable && !master && !moving && ack_assert;
        sl_cnt     <= 4'h0;
        addr_match <= 1'b0;
      end else if (stop_seen) begin
        sl_active  <= 1'b0;
        addr_match <= 1'b0;
      end else if (sl_active && scl_rise) begin
        sl_shift <= sl_nx;
        sl_cnt   <= sl_cnt + 4'h1;
        if (sl_done) begin
          sl_active  <= 1'b0;
          addr_match <= own_hit || gc_hit;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      lo_cnt <= 9'h000;
    end else if (ce_in) begin
      lo_cnt <= (state == S_LOW) ? lo_cnt + 9'h001 : 9'h000;
    end
  end

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);

  flag_set_a: assert property (ce_in && set_evt |=> event_flag)
    else $error("event flag not set on state entry");
  flag_keep_a: assert property (ce_in && event_flag && !clr_evt |=> event_flag)
    else $error("event flag cleared without software");
  scl_hold_a: assert property (ce_in && event_flag && scl_low && !wr_ctrl |=> scl_low)
    else $error("SCL released while event flag set");
  code_align_a: assert property (event_flag |-> state_code[2:0] == 3'h0)
    else $error("state code not a multiple of eight");
  stop_clear_a: assert property (ce_in && stop_seen |=> !stop_req)
    else $error("stop request not cleared by STOP");
  low_time_a: assert property (ce_in && state == S_LOW && tick |->
                               lo_cnt == 9'h0FF - {1'b0, rate})
    else $error("SCL low period wrong length");
  msb_out_a: assert property (ce_in && enable && state == S_HOLD && !event_flag &&
                              !stop_req && !start_req && !rx_mode
                              |=> sda_low == !$past(shift[7]))
    else $error("first bit out is not the MSB");
  shift_in_a: assert property (ce_in && enable && state == S_HIGH && tick &&
                               bit_cnt != ACK_BIT |=> shift == $past(shift_nx))
    else $error("bus bit not shifted in");
  match_gc_a: assert property (ce_in && sl_done && !start_seen && !stop_seen &&
                               own[0] && sl_nx[7:1] == GEN_CALL |=> addr_match)
    else $error("general call not recognised");
  tx_code_a: assert property (ce_in && enable && state == S_HIGH && tick && !arb &&
                              bit_cnt == ACK_BIT && !addr_ph && !rx_mode && !sda_s
                              |=> state_code == CODE_DT_ACK && event_flag)
    else $error("acked data byte gave wrong code");
  start_code_a: assert property (ce_in && enable && state == S_START && tick &&
                                 sda_low && !master
                                 |=> state_code == CODE_START && scl_low && event_flag)
    else $error("START did not report its code");

  start_c: cover property (event_flag && state_code == CODE_START);
  data_tx_c: cover property (event_flag && state_code == CODE_DT_ACK);
  data_rx_c: cover property (event_flag && state_code == CODE_DR_NACK);
  stop_c: cover property (stop_seen ##1 !busy);

endmodule

// file: verif/tw_slave_model.sv
// Behavioural slave on the two-wire bus: one address byte and one data byte per frame
`timescale 1ns/1ns
module tw_slave_model #(
  parameter logic [6:0] ADDR = 7'h2A
) (
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  input  wire logic [7:0] tx_in,
  output      logic       sda_oe_out,
  output      logic [7:0] rx_out
);
  logic [7:0] b;
  logic       hit;
  task automatic get_byte(output logic [7:0] v);
    repeat (8) @(posedge scl_in) v = {v[6:0], sda_in};
  endtask
  task automatic ack_slot(input logic a);
    @(negedge scl_in) sda_oe_out = a;
    @(negedge scl_in) sda_oe_out = 1'b0;
  endtask
  initial sda_oe_out = 1'b0;
  always begin
    @(negedge sda_in iff scl_in === 1'b1);
    get_byte(b);
    hit = (b[7:1] == ADDR);
    ack_slot(hit);
    if (hit && b[0]) begin
      for (int i = 7; i >= 0; i--) begin
        sda_oe_out = ~tx_in[i];
        @(negedge scl_in);
      end
      sda_oe_out = 1'b0;
    end else if (hit) begin
      get_byte(rx_out);
      ack_slot(1'b1);
    end
  end
endmodule

// file: verif/twowire_bus_rate_data_status_tb.sv
// Self-checking bench for the two-wire master with a slave model
`timescale 1ns/1ns
module twowire_bus_rate_data_status_tb;
  import tw_pkg::*;
  localparam logic [6:0] SLV = 7'h2A;
  logic             clk_sys_in = 1'b0;
  logic             reset_in   = 1'b1;
  logic             cyc        = 1'b0;
  logic             stb        = 1'b0;
  logic             we         = 1'b0;
  logic [ADR_W-1:0] adr        = '0;
  logic [31:0]      wdat       = '0;
  logic [31:0]      rdat;
  logic             ack;
  logic             scl_oe;
  logic             sda_oe;
  logic             slv_oe;
  logic [7:0]       tx         = 8'h00;
  logic [7:0]       rx;
  logic [7:0]       q;
  logic [7:0]       d;
  logic [7:0]       p;
  logic             ext_scl    = 1'b0;
  logic             ext_sda    = 1'b0;
  int               k          = 0;
  wire              scl_w      = ~(scl_oe | ext_scl);
  wire              sda_w      = ~(sda_oe | slv_oe | ext_sda);
  int               errors     = 0;
  int               total_checks = 0;
  int               seed       = 32'hB3204360;

  always #5 clk_sys_in = ~clk_sys_in;

  tw_twowire dut_u (.clk_sys_in(clk_sys_in), .reset_in(reset_in), .ce_in(1'b1),
    .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hF),
    .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack), .scl_in(scl_w), .scl_out(),
    .scl_oe_out(scl_oe), .sda_in(sda_w), .sda_out(), .sda_oe_out(sda_oe));

  tw_slave_model #(.ADDR(SLV)) slv_u (.scl_in(scl_w), .sda_in(sda_w), .tx_in(tx),
    .sda_oe_out(slv_oe), .rx_out(rx));

  task final_report;
    if (errors == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic fail;
    errors++;
    final_report();
  endtask

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask

  // Slave address recognition: own address bits 7..1, or general call when enabled
  function automatic logic [7:0] exp_match(input logic [7:0] own, input logic [7:0] a);
    return {7'h00, (a[7:1] == own[7:1]) || (own[0] && a[7:1] == 7'h00)};
  endfunction

  // External master at 80 ns: START, nine clocks MSB first, lines freed without STOP
  task automatic ext_frame(input logic [8:0] v);
    ext_sda <= 1'b1;
    repeat (4) @(posedge clk_sys_in);
    for (int i = 8; i >= 0; i--) begin
      ext_scl <= 1'b1;
      repeat (2) @(posedge clk_sys_in);
      ext_sda <= ~v[i];
      repeat (2) @(posedge clk_sys_in);
      ext_scl <= 1'b0;
      repeat (4) @(posedge clk_sys_in);
    end
    ext_scl <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    ext_sda <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    ext_scl <= 1'b0;
  endtask

  task automatic bus(input logic w, input logic [7:0] i, input logic [7:0] v);
    int n;
    n = 0;
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= {i, 2'b00};
    wdat <= {24'h0, v};
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_sys_in);
    if (n >= 20)
      fail();
  endtask

  // Poll the event flag, then compare the state code
  task automatic wait_code(input logic [7:0] e);
    int n;
    n = 0;
    do begin
      bus(1'b0, IDX_CTRL, 8'h00);
      n++;
    end while (q[3] !== 1'b1 && n < 500);
    if (n >= 500)
      fail();
    bus(1'b0, IDX_CODE, 8'h00);
    chk("state_code", e, q);
  endtask

  // Stop request must drop once the STOP is on the bus
  task automatic wait_stop;
    int n;
    n = 0;
    do begin
      bus(1'b0, IDX_CTRL, 8'h00);
      n++;
    end while (q[4] !== 1'b0 && n < 500);
    if (n >= 500)
      fail();
    bus(1'b0, IDX_CODE, 8'h00);
    chk("idle_code", CODE_IDLE, q);
  endtask

  task automatic send(input logic [7:0] v, input logic [7:0] e);
    bus(1'b1, IDX_DATA, v);
    bus(1'b1, IDX_CTRL, 8'h44);
    wait_code(e);
  endtask

  initial begin
    repeat (3) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    @(posedge clk_sys_in);
    bus(1'b0, IDX_CODE, 8'h00);
    chk("code_rst", CODE_IDLE, q);
    bus(1'b0, IDX_ADDR, 8'h00);
    chk("own_rst", RST_ADDR, q);
    bus(1'b0, 8'h10, 8'h00);
    chk("unmapped", 8'h00, q);
    bus(1'b1, IDX_CODE, 8'h55);
    bus(1'b0, IDX_CODE, 8'h00);
    chk("code_ro", CODE_IDLE, q);
    d = 8'($random(seed));
    bus(1'b1, IDX_ADDR, d);
    bus(1'b0, IDX_ADDR, 8'h00);
    chk("own_rw", d, q);
    p = 8'hF0 | (8'($random(seed)) & 8'h0C);
    bus(1'b1, IDX_RATE, p);
    bus(1'b0, IDX_RATE, 8'h00);
    chk("rate_rw", p, q);
    tx <= 8'($random(seed));
    d = 8'($random(seed));
    bus(1'b1, IDX_CTRL, 8'h64);
    wait_code(CODE_START);
    send({SLV, 1'b0}, CODE_AW_ACK);
    send(d, CODE_DT_ACK);
    chk("slave_rx", d, rx);
    bus(1'b0, IDX_DATA, 8'h00);
    chk("shift_tx", d, q);
    bus(1'b1, IDX_CTRL, 8'h54);
    wait_stop();
    bus(1'b1, IDX_CTRL, 8'h64);
    wait_code(CODE_START);
    send({SLV, 1'b1}, CODE_AR_ACK);
    bus(1'b1, IDX_CTRL, 8'h40);
    wait_code(CODE_DR_NACK);
    bus(1'b0, IDX_DATA, 8'h00);
    chk("shift_rx", tx, q);
    bus(1'b1, IDX_CTRL, 8'h60);
    wait_code(CODE_RSTART);
    send({~SLV, 1'b0}, CODE_AW_NACK);
    bus(1'b1, IDX_CTRL, 8'h74);
    wait_code(CODE_START);
    send({~SLV, 1'b1}, CODE_AR_NACK);
    bus(1'b1, IDX_CTRL, 8'h54);
    wait_stop();
    bus(1'b1, IDX_ADDR, d | 8'h01);
    bus(1'b1, IDX_CTRL, 8'h46);
    ext_frame(9'h001);
    bus(1'b0, IDX_CTRL, 8'h00);
    chk("ext_ctrl", 8'hC6 | exp_match(d | 8'h01, 8'h00), q);
    k = 0;
    do begin
      bus(1'b0, IDX_CTRL, 8'h00);
      k++;
    end while (q[7] !== 1'b0 && k < 500);
    chk("free_busy", 8'h00, q & 8'h80);
    final_report();
  end
endmodule
